// [common/bps_pkg.sv]
package bps_pkg;

    // placement of the status word in configuration space
    localparam logic [11:0] STATUS_OFFSET     = 12'h006;
    localparam logic [11:0] STATUS_DWORD_ADDR = 12'h004;
    localparam logic [15:0] STATUS_RESET      = 16'h0010;

    // byte lanes of the aligned dword that carry the status word
    localparam int unsigned STATUS_LANE_LO = 2;
    localparam int unsigned STATUS_LANE_HI = 3;

    // status word bit positions
    localparam int unsigned POISON_DETECTED_BIT   = 15;
    localparam int unsigned ERROR_MESSAGE_BIT     = 14;
    localparam int unsigned UNSUPPORTED_CPL_BIT   = 13;
    localparam int unsigned ABORT_CPL_RX_BIT      = 12;
    localparam int unsigned ABORT_CPL_TX_BIT      = 11;
    localparam int unsigned SELECT_TIMING_MSB     = 10;
    localparam int unsigned SELECT_TIMING_LSB     = 9;
    localparam int unsigned POISONED_DATA_BIT     = 8;
    localparam int unsigned BACK_TO_BACK_BIT      = 7;
    localparam int unsigned RESERVED_6_BIT        = 6;
    localparam int unsigned HIGH_SPEED_BIT        = 5;
    localparam int unsigned CAPABILITY_LIST_BIT   = 4;
    localparam int unsigned INTERRUPT_PENDING_BIT = 3;

    // fixed read values of the select timing and capability list fields
    localparam logic [1:0] SELECT_TIMING_VALUE = 2'h0;
    localparam logic       CAPABILITY_LIST_VALUE = 1'b1;

    // index of each sticky flag inside the flag bank
    localparam int unsigned FLAG_COUNT         = 6;
    localparam int unsigned FLAG_POISON        = 0;
    localparam int unsigned FLAG_ERROR_MESSAGE = 1;
    localparam int unsigned FLAG_UNSUPPORTED   = 2;
    localparam int unsigned FLAG_ABORT_RX      = 3;
    localparam int unsigned FLAG_ABORT_TX      = 4;
    localparam int unsigned FLAG_POISONED_DATA = 5;

    // configuration access sequencing
    typedef enum logic [0:0] {
        BPS_IDLE   = 1'b0,
        BPS_ANSWER = 1'b1
    } bps_access_type;

endpackage : bps_pkg

// [src/bps_flag_bank.sv]
`timescale 1ns/1ns

// bank of sticky flags: set by hardware events, cleared by software
module bps_flag_bank #(
    parameter int unsigned WIDTH = 6
) (
    // clock and reset
    input  wire logic             ref_clk,
    input  wire logic             reset,
    // per-flag set and clear strobes
    input  wire logic [WIDTH-1:0] set_vec,
    input  wire logic [WIDTH-1:0] clear_vec,
    // held flags
    output logic      [WIDTH-1:0] flags
);

    logic [WIDTH-1:0] flags_r;
    logic [WIDTH-1:0] flags_nxt;

    // set beats clear
    // the set term is ored in after the clear, so a coincident event
    // survives the clearing write
    always_comb begin
        flags_nxt = (flags_r & ~clear_vec) | set_vec;
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            flags_r <= '0;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    assign flags = flags_r;

endmodule : bps_flag_bank

// [src/bps_status_reg.sv]
`timescale 1ns/1ns

// Behaviour
// - 16-bit status at 06h, resets 0010h
// - error flags sticky, other bits read-only
// - bit 15 set on any poisoned TLP
// - bit 14 set on error message if enabled
// - bit 13 set on unsupported-request completion
// - bit 12 set on completer-abort completion received
// - bit 11 set when completer abort returned
// - bit 8 poisoned data, gated by enable
// - bits 10:9 always read 00b
// - bits 7, 6, 5, 2:0 read zero
// - bit 4 always reads one
// - bit 3 always reads zero
// - two command enables, reset zero, are inputs
module bps_status_reg #(
    parameter int unsigned ADDR_WIDTH = 12
) (
    // clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  reset,
    // configuration access port
    input  wire logic                  cfg_req,
    input  wire logic                  cfg_write,
    input  wire logic [ADDR_WIDTH-1:0] cfg_addr,
    input  wire logic [3:0]            cfg_byte_en,
    input  wire logic [31:0]           cfg_wdata,
    output logic                       cfg_ack,
    output logic      [31:0]           cfg_rdata,
    output logic                       cfg_unmapped,
    // command register enables
    input  wire logic                  error_report_enable,
    input  wire logic                  poison_response_enable,
    // primary link events, one-cycle pulses
    input  wire logic                  poisoned_tlp_rx,
    input  wire logic                  error_message_tx,
    input  wire logic                  unsupported_cpl_rx,
    input  wire logic                  abort_cpl_rx,
    input  wire logic                  abort_cpl_tx,
    input  wire logic                  poisoned_cpl_rx,
    input  wire logic                  write_poisoned,
    // status view
    output logic      [15:0]           primary_link_status,
    output logic                       error_flag_any
);

    localparam int unsigned FW = bps_pkg::FLAG_COUNT;

    // assemble the 16-bit status word from the sticky flags
    function automatic logic [15:0] build_status(
        input logic [FW-1:0] f
    );
        logic [15:0] s;
        s = 16'h0000;
        s[bps_pkg::POISON_DETECTED_BIT] = f[bps_pkg::FLAG_POISON];
        s[bps_pkg::ERROR_MESSAGE_BIT]   = f[bps_pkg::FLAG_ERROR_MESSAGE];
        s[bps_pkg::UNSUPPORTED_CPL_BIT] = f[bps_pkg::FLAG_UNSUPPORTED];
        s[bps_pkg::ABORT_CPL_RX_BIT]    = f[bps_pkg::FLAG_ABORT_RX];
        s[bps_pkg::ABORT_CPL_TX_BIT]    = f[bps_pkg::FLAG_ABORT_TX];
        s[bps_pkg::POISONED_DATA_BIT]   = f[bps_pkg::FLAG_POISONED_DATA];
        s[bps_pkg::SELECT_TIMING_MSB:bps_pkg::SELECT_TIMING_LSB] =
            bps_pkg::SELECT_TIMING_VALUE;
        s[bps_pkg::BACK_TO_BACK_BIT] = 1'b0;
        s[bps_pkg::RESERVED_6_BIT]   = 1'b0;
        s[bps_pkg::HIGH_SPEED_BIT]   = 1'b0;
        s[2:0]                       = 3'h0;
        s[bps_pkg::CAPABILITY_LIST_BIT] = bps_pkg::CAPABILITY_LIST_VALUE;
        s[bps_pkg::INTERRUPT_PENDING_BIT] = 1'b0;
        return s;
    endfunction : build_status

    // pick the flag bits out of a 16-bit write-one mask
    function automatic logic [FW-1:0] mask_to_flags(
        input logic [15:0] m
    );
        logic [FW-1:0] f;
        f = '0;
        f[bps_pkg::FLAG_POISON]        = m[bps_pkg::POISON_DETECTED_BIT];
        f[bps_pkg::FLAG_ERROR_MESSAGE] = m[bps_pkg::ERROR_MESSAGE_BIT];
        f[bps_pkg::FLAG_UNSUPPORTED]   = m[bps_pkg::UNSUPPORTED_CPL_BIT];
        f[bps_pkg::FLAG_ABORT_RX]      = m[bps_pkg::ABORT_CPL_RX_BIT];
        f[bps_pkg::FLAG_ABORT_TX]      = m[bps_pkg::ABORT_CPL_TX_BIT];
        f[bps_pkg::FLAG_POISONED_DATA] = m[bps_pkg::POISONED_DATA_BIT];
        return f;
    endfunction : mask_to_flags

    // expand two byte enables into a 16-bit lane mask
    function automatic logic [15:0] lane_mask(
        input logic be_hi,
        input logic be_lo
    );
        return {{8{be_hi}}, {8{be_lo}}};
    endfunction : lane_mask

    // address of the status dword at this bus width
    localparam logic [ADDR_WIDTH-1:0] STATUS_ADDR =
        ADDR_WIDTH'(bps_pkg::STATUS_DWORD_ADDR);

    // true when an access falls on the dword holding the status word;
    // the low two address bits pick a byte and lanes do that job here
    function automatic logic status_addr_match(
        input logic [ADDR_WIDTH-1:0] a
    );
        return a[ADDR_WIDTH-1:2] == STATUS_ADDR[ADDR_WIDTH-1:2];
    endfunction : status_addr_match

    // access protocol as seen from the requester:
    // - a request is taken on the first edge that sees it while idle
    // - the answer cycle follows; acknowledge stands for that one cycle
    //   and read data is already registered when it is sampled
    // - the requester drops its request at the acknowledge edge, so the
    //   machine is idle again before any new request can be seen
    // - the status word sits in the upper half of its dword; the lower
    //   half belongs to the command word, which lives outside this block,
    //   so it always reads zero here
    // - a write clears flags at the taking edge, while a read returns
    //   the flags as they stood before that edge

    // access sequencing state
    bps_pkg::bps_access_type state_r;
    bps_pkg::bps_access_type state_nxt;

    // decoded access
    logic          accept;
    logic          addr_hit;
    logic          write_hit;
    logic [15:0]   clear_mask;
    logic [FW-1:0] clear_vec;

    // qualified events and held flags
    logic [FW-1:0] set_vec;
    logic [FW-1:0] flags;
    logic [15:0]   status_word;

    // registered answer
    logic [31:0]   rdata_r;
    logic [31:0]   rdata_nxt;
    logic          unmapped_r;
    logic          unmapped_nxt;
    logic          any_r;
    logic          any_nxt;

    // status at offset 06h
    // a request is taken only from idle, so a request still held in the
    // answer cycle is not taken a second time
    always_comb begin
        accept    = cfg_req && (state_r == bps_pkg::BPS_IDLE);
        addr_hit  = status_addr_match(cfg_addr);
        write_hit = accept && cfg_write && addr_hit;
    end

    // next access state: one answer cycle per accepted request
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            bps_pkg::BPS_IDLE: begin
                if (accept) begin
                    state_nxt = bps_pkg::BPS_ANSWER;
                end
            end
            bps_pkg::BPS_ANSWER: begin
                state_nxt = bps_pkg::BPS_IDLE;
            end
            default: begin
                state_nxt = bps_pkg::BPS_IDLE;
            end
        endcase
    end

    // access state register
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_r <= bps_pkg::BPS_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // acknowledge stands for the single answer cycle
    always_comb begin
        cfg_ack = (state_r == bps_pkg::BPS_ANSWER);
    end

    // write one clears
    // only enabled byte lanes may clear; a zero bit or a disabled lane
    // leaves its flag alone, so a partial write cannot wipe other flags
    always_comb begin
        clear_mask = cfg_wdata[31:16] &
            lane_mask(cfg_byte_en[bps_pkg::STATUS_LANE_HI],
                      cfg_byte_en[bps_pkg::STATUS_LANE_LO]);
        clear_vec = '0;
        if (write_hit) begin
            clear_vec = mask_to_flags(clear_mask);
        end
    end

    // event qualification, one set strobe per flag
    always_comb begin
        set_vec = '0;
        set_vec[bps_pkg::FLAG_POISON] = poisoned_tlp_rx;
        set_vec[bps_pkg::FLAG_ERROR_MESSAGE] =
            error_message_tx && error_report_enable;
        set_vec[bps_pkg::FLAG_UNSUPPORTED] = unsupported_cpl_rx;
        set_vec[bps_pkg::FLAG_ABORT_RX] = abort_cpl_rx;
        set_vec[bps_pkg::FLAG_ABORT_TX] = abort_cpl_tx;
        set_vec[bps_pkg::FLAG_POISONED_DATA] =
            (poisoned_cpl_rx || write_poisoned) && poison_response_enable;
    end

    bps_flag_bank #(
        .WIDTH (FW)
    ) bps_flag_bank_i (
        .ref_clk   (ref_clk),
        .reset     (reset),
        .set_vec   (set_vec),
        .clear_vec (clear_vec),
        .flags     (flags)
    );

    // fixed fields are filled in by the builder
    always_comb begin
        status_word = build_status(flags);
    end

    // read data for the accepted request; other accesses read zero
    always_comb begin
        rdata_nxt = rdata_r;
        if (accept) begin
            if (addr_hit && !cfg_write) begin
                rdata_nxt = {status_word, 16'h0000};
            end else begin
                rdata_nxt = 32'h0000_0000;
            end
        end
    end

    // read data register, held until the next accepted request
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rdata_r <= 32'h0000_0000;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // an access off the status dword is flagged rather than answered
    // with data; the flag holds until the next accepted request
    always_comb begin
        unmapped_nxt = unmapped_r;
        if (accept) begin
            unmapped_nxt = !addr_hit;
        end
    end

    // unmapped register
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            unmapped_r <= 1'b0;
        end else begin
            unmapped_r <= unmapped_nxt;
        end
    end

    // summary of the held flags, one cycle behind them
    always_comb begin
        any_nxt = |flags;
    end

    // summary register
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            any_r <= 1'b0;
        end else begin
            any_r <= any_nxt;
        end
    end

    // outputs
    assign cfg_rdata           = rdata_r;
    assign cfg_unmapped        = unmapped_r;
    assign primary_link_status = status_word;
    assign error_flag_any      = any_r;

endmodule : bps_status_reg

// [dv/bps_link_partner.sv]
`timescale 1ns/1ns

// link side: a held request gives one event pulse, as each TLP counts once
module bps_link_partner (
    input  wire logic       ref_clk,
    input  wire logic [6:0] req,
    output logic      [6:0] ev
);
    logic [6:0] prev_r = 7'h00;
    always_ff @(posedge ref_clk) begin
        prev_r <= req;
        ev <= req & ~prev_r;
    end
endmodule : bps_link_partner

// [dv/bps_status_reg_sva.sv]
`timescale 1ns/1ns

// flags may take one or two edges to show after their event
module bps_sva (
    input wire logic        ref_clk, reset, cfg_req,
    input wire logic        error_report_enable, poison_response_enable,
    input wire logic        poisoned_tlp_rx, error_message_tx,
    input wire logic        unsupported_cpl_rx, abort_cpl_rx, abort_cpl_tx,
    input wire logic        poisoned_cpl_rx, write_poisoned,
    input wire logic [15:0] primary_link_status
);
    wire [15:0] s = primary_link_status;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    fixed_zero_a: assert property ((s & 16'h06ef) == 16'h0000)
        else $error("fixed bit set");
    cap_list_a: assert property (s[4]) else $error("cap bit low");
    poison_set_a: assert property (poisoned_tlp_rx |-> ##[1:2] s[15])
        else $error("bit 15 not set");
    msg_set_a: assert property (error_message_tx && error_report_enable
        |-> ##[1:2] s[14]) else $error("bit 14 not set");
    unsup_set_a: assert property (unsupported_cpl_rx |-> ##[1:2] s[13])
        else $error("bit 13 not set");
    abort_rx_a: assert property (abort_cpl_rx |-> ##[1:2] s[12])
        else $error("bit 12 not set");
    abort_tx_a: assert property (abort_cpl_tx |-> ##[1:2] s[11])
        else $error("bit 11 not set");
    data_set_a: assert property ((poisoned_cpl_rx || write_poisoned) &&
        poison_response_enable |-> ##[1:2] s[8])
        else $error("bit 8 not set");
    flag_hold_a: assert property (s[15] && !cfg_req && !$past(cfg_req)
        |=> s[15]) else $error("bit 15 lost");
endmodule : bps_sva

bind bps_status_reg bps_sva bps_sva_i (.*);

// [dv/bps_status_reg_tb.sv]
`timescale 1ns/1ns

module bps_status_reg_tb;
    localparam logic [11:0] A = bps_pkg::STATUS_DWORD_ADDR;
    logic ref_clk = 0, reset = 1, cfg_req = 0, cfg_write = 0, ere = 0, pre = 0;
    logic [11:0] cfg_addr = 12'h000;
    logic [3:0]  cfg_byte_en = 4'h0;
    logic [31:0] cfg_wdata = 32'h0000_0000, cfg_rdata;
    logic [15:0] pls, q;
    logic [6:0]  req = 7'h00, ev;
    logic        cfg_ack, unm, any_flag;
    int          err_count = 0, total_checks = 0;
    bps_link_partner bps_link_partner_i (.ref_clk(ref_clk), .req(req), .ev(ev));
    bps_status_reg bps_status_reg_i (.ref_clk(ref_clk), .reset(reset),
        .cfg_req(cfg_req), .cfg_write(cfg_write), .cfg_addr(cfg_addr),
        .cfg_byte_en(cfg_byte_en), .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack),
        .cfg_rdata(cfg_rdata), .cfg_unmapped(unm),
        .error_report_enable(ere), .poison_response_enable(pre),
        .poisoned_tlp_rx(ev[0]), .error_message_tx(ev[1]),
        .unsupported_cpl_rx(ev[2]), .abort_cpl_rx(ev[3]),
        .abort_cpl_tx(ev[4]), .poisoned_cpl_rx(ev[5]), .write_poisoned(ev[6]),
        .primary_link_status(pls), .error_flag_any(any_flag));
    initial forever #20 ref_clk = ~ref_clk;
    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : final_report
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: %h not %h", $time, got, exp);
        end
    endtask : check
    // request held until acknowledged, bounded wait
    task automatic acc(input logic w, input logic [11:0] a,
                       input logic [15:0] d);
        int n = 0;
        cfg_req <= 1;
        cfg_write <= w;
        cfg_addr <= a;
        cfg_byte_en <= 4'hc;
        cfg_wdata <= {d, 16'h0000};
        do @(posedge ref_clk); while (cfg_ack !== 1'b1 && ++n < 50);
        if (n >= 50) begin
            err_count++;
            final_report();
        end
        q = cfg_rdata[31:16];
        cfg_req <= 0;
        @(posedge ref_clk);
    endtask : acc
    task automatic ev_chk(input logic [6:0] m, input logic [15:0] e);
        req <= m;
        @(posedge ref_clk);
        req <= 7'h00;
        repeat (3) @(posedge ref_clk);
        acc(0, A, 16'h0000);
        check(q, e);
    endtask : ev_chk
    initial begin
        repeat (8) @(posedge ref_clk);
        reset <= 0;
        @(posedge ref_clk);
        ev_chk(7'h00, 16'h0010);
        acc(1, A, 16'hffff);
        ev_chk(7'h00, 16'h0010);
        ev_chk(7'h7f, 16'hb810);
        check({15'h0000, any_flag}, 16'h0001);
        acc(1, A, 16'h8000);
        ev_chk(7'h00, 16'h3810);
        ere <= 1;
        pre <= 1;
        ev_chk(7'h22, 16'h7910);
        acc(1, A, 16'h0100);
        ev_chk(7'h40, 16'h7910);
        acc(1, A, 16'hf900);
        ev_chk(7'h00, 16'h0010);
        check({15'h0000, any_flag}, 16'h0000);
        acc(0, 12'h008, 16'h0000);
        check({15'h0000, unm}, 16'h0001);
        final_report();
    end
endmodule : bps_status_reg_tb
